// file: verilog/link_frame_pkg.sv
// Package: constants, enumerations and carriers of the link framer
`default_nettype none
package link_frame_pkg;

  localparam logic [7:0] FLAG_OCTET = 8'h7E;
  localparam int MAX_DEST = 16;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [2:0] FLAG_RUN = 3'h6;
  localparam logic [3:0] OCT_BITS = 4'h8;
  localparam logic [2:0] OCT_LAST_BIT = 3'h7;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {OP_UNACK, OP_CONN, OP_ACK, OP_DECOUP} op_type_t;
  typedef enum logic [1:0] {KIND_UNNUM, KIND_INFO, KIND_SUPER, KIND_NONE} frame_kind_t;

  typedef struct packed {
    logic [6:0] src;
    logic resp;
    frame_kind_t kind;
    logic [4:0] ndest;
  } tx_hdr_t;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } tx_word_t;

  typedef struct packed {
    logic [6:0] src;
    logic resp;
    frame_kind_t kind;
    logic ok;
  } rx_stat_t;

  function automatic logic kind_ok(op_type_t op, frame_kind_t k);
    kind_ok = (k == KIND_UNNUM) || (k == KIND_INFO && op == OP_CONN) ||
      (k == KIND_SUPER && (op == OP_CONN || op == OP_DECOUP));
  endfunction

  // Low control bits give the frame kind: x0 info, 01 supervisory, 11 unnumbered
  function automatic frame_kind_t kind_of(logic [7:0] ctl);
    kind_of = !ctl[0] ? KIND_INFO : (ctl[1] ? KIND_UNNUM : KIND_SUPER);
  endfunction

endpackage
`default_nettype wire

// file: verilog/tx_octet_fifo.sv
// Synchronous FIFO that buffers transmit words ahead of the framer
`timescale 1ns/1ps
`default_nettype none
module tx_octet_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  // DEPTH must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic wr;
  logic rd;

  assign wr = i_valid && o_ready;
  assign rd = o_valid && i_ready;
  assign o_valid = (cnt_r != '0);
  assign o_data = mem[rp_r];
  assign cnt_nxt = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);

  always_ff @(posedge i_clk) begin
    if (wr) begin
      mem[wp_r] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      o_ready <= 1'b1;
    end else begin
      wp_r <= wr ? wp_r + AW'(1) : wp_r;
      rp_r <= rd ? rp_r + AW'(1) : rp_r;
      cnt_r <= cnt_nxt;
      o_ready <= (cnt_nxt != (AW+1)'(DEPTH));
    end
  end

endmodule
`default_nettype wire

// file: verilog/link_frame_addressing.sv
// Link frame builder and parser with single-octet addressing and bit stuffing
`timescale 1ns/1ps
`default_nettype none

// Contract
// (R1) Fields: flag, address, control, information, check, flag; the code builds and parses no check field
// (R2) Frames open and close with flag 01111110
// (R3) Receiver synchronises frames on flag detection
// (R4) Unnumbered frames allowed in every operation type
// (R5) Information frames only in connection mode
// (R6) Supervisory frames not in unacknowledged connectionless
// (R7) Single-octet addressing always supported
// (R8) One address width per net, never mixed
// (R9) Each single-mode address is one octet
// (R10) Source octet: command/response LSB, 7-bit source
// (R11) Destination octet: extension LSB, 7-bit address
// (R12) Extension bit 0 chains another destination
// (R13) Extension bit 1 ends destination list
// (R14) Command/response bit 0 command, 1 response
// (R15) One to sixteen destination octets
// (R16) Receiver skips destination value zero
// (R17) Zero inserted after five ones, removed on receive
module link_frame_addressing
  import link_frame_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire op_type_t I_OP_TYPE,
  input wire logic I_ADDR_FOUR,
  input wire logic I_TX_START,
  input wire tx_hdr_t I_TX_HDR,
  output logic O_TX_BUSY,
  output logic O_TX_ERR,
  input wire logic I_TX_VALID,
  input wire tx_word_t I_TX_WORD,
  output logic O_TX_READY,
  output logic O_TX_BIT,
  output logic O_TX_BIT_VALID,
  input wire logic I_RX_BIT,
  input wire logic I_RX_BIT_VALID,
  output logic [6:0] O_RX_DEST,
  output logic O_RX_DEST_VALID,
  output logic [7:0] O_RX_DATA,
  output logic O_RX_DATA_VALID,
  output logic O_RX_END,
  output rx_stat_t O_RX_STAT,
  output logic O_RX_ERR
);

  typedef enum {TX_IDLE, TX_OPEN, TX_SRC, TX_DEST, TX_BODY, TX_CLOSE, TX_DROP} tx_st_t;
  typedef enum {RX_HUNT, RX_SRC, RX_DEST, RX_BODY} rx_st_t;

  // Transmit side
  tx_st_t tx_st_r;
  tx_st_t tx_st_nxt;
  tx_hdr_t hdr_r;
  logic [4:0] dcnt_r;
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  logic stuff_en_r;
  logic [2:0] ones_r;
  logic [2:0] ones_nxt;
  logic f_valid;
  tx_word_t f_word;
  logic f_pop;
  logic start_ok;
  logic ndest_ok;
  logic stuff_now;
  logic ser_free;
  logic ld;
  logic ld_stuff;
  logic [7:0] ld_oct;
  logic dest_ext;
  logic fetch_st;

  tx_octet_fifo #(
    .WIDTH($bits(tx_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_valid(I_TX_VALID),
    .i_data(I_TX_WORD),
    .o_ready(O_TX_READY),
    .o_valid(f_valid),
    .o_data(f_word),
    .i_ready(f_pop)
  );

  // Only the single-octet width is built; a net set for four octets is refused
  assign ndest_ok = (I_TX_HDR.ndest != 5'h0) && (I_TX_HDR.ndest <= 5'(MAX_DEST)); // see (R15)
  assign start_ok = kind_ok(I_OP_TYPE, I_TX_HDR.kind) && !I_ADDR_FOUR && ndest_ok; // see (R4) (R5) (R6) (R8)
  assign stuff_now = stuff_en_r && (ones_r == STUFF_RUN); // see (R17)
  assign ser_free = (cnt_r == 4'h0) && !stuff_now;
  assign fetch_st = (tx_st_r == TX_DEST) || (tx_st_r == TX_BODY);
  assign ld = ser_free && (tx_st_r == TX_OPEN || tx_st_r == TX_SRC ||
    tx_st_r == TX_CLOSE || (fetch_st && f_valid));
  assign f_pop = (ld && fetch_st) || (tx_st_r == TX_DROP && f_valid);
  assign dest_ext = (dcnt_r == 5'h1); // see (R12) (R13)
  // Each address is one octet, low bit carries the command/response or extension bit
  assign ld_oct = (tx_st_r == TX_SRC) ? {hdr_r.src, hdr_r.resp} : // see (R7) (R9) (R10) (R14)
    (tx_st_r == TX_DEST) ? {f_word.data[6:0], dest_ext} : // see (R11)
    (tx_st_r == TX_BODY) ? f_word.data : FLAG_OCTET; // see (R2)
  assign ld_stuff = (tx_st_r != TX_OPEN) && (tx_st_r != TX_CLOSE);
  assign ones_nxt = stuff_now ? 3'h0 :
    (cnt_r != 4'h0) ? (sh_r[0] ? ones_r + 3'h1 : 3'h0) : ones_r;

  always_comb begin
    tx_st_nxt = tx_st_r;
    unique case (tx_st_r)
      TX_IDLE: if (I_TX_START) tx_st_nxt = start_ok ? TX_OPEN : TX_DROP;
      TX_OPEN: if (ld) tx_st_nxt = TX_SRC; // see (R1)
      TX_SRC: if (ld) tx_st_nxt = TX_DEST;
      TX_DEST: if (ld && dest_ext) tx_st_nxt = TX_BODY; // see (R13)
      TX_BODY: if (ld && f_word.last) tx_st_nxt = TX_CLOSE;
      TX_CLOSE: if (ld) tx_st_nxt = TX_IDLE;
      TX_DROP: if (f_pop && f_word.last) tx_st_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tx_st_r <= TX_IDLE;
      hdr_r <= '0;
      dcnt_r <= 5'h0;
      O_TX_BUSY <= 1'b0;
      O_TX_ERR <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      hdr_r <= (tx_st_r == TX_IDLE && I_TX_START) ? I_TX_HDR : hdr_r;
      dcnt_r <= (tx_st_r == TX_IDLE) ? I_TX_HDR.ndest :
        (ld && tx_st_r == TX_DEST) ? dcnt_r - 5'h1 : dcnt_r;
      O_TX_BUSY <= (tx_st_nxt != TX_IDLE);
      O_TX_ERR <= (tx_st_r == TX_IDLE) && I_TX_START && !start_ok;
    end
  end

  // Serialiser, least significant bit first; the stuffed zero costs one cycle
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      stuff_en_r <= 1'b0;
      ones_r <= 3'h0;
      O_TX_BIT <= 1'b0;
      O_TX_BIT_VALID <= 1'b0;
    end else begin
      if (ld) begin
        sh_r <= ld_oct;
        cnt_r <= OCT_BITS;
        stuff_en_r <= ld_stuff;
      end else if (!stuff_now && cnt_r != 4'h0) begin
        sh_r <= {1'b0, sh_r[7:1]};
        cnt_r <= cnt_r - 4'h1;
      end
      ones_r <= ones_nxt;
      O_TX_BIT <= !stuff_now && sh_r[0]; // see (R17)
      O_TX_BIT_VALID <= stuff_now || (cnt_r != 4'h0);
    end
  end

  // Receive side; pin inputs pass two flip-flops first
  rx_st_t rx_st_r;
  logic bit_s1_r;
  logic bit_s2_r;
  logic val_s1_r;
  logic val_s2_r;
  logic val_s3_r;
  logic [7:0] win_r;
  logic [2:0] rones_r;
  logic [7:0] rb_r;
  logic [2:0] rbc_r;
  logic [3:0] rdc_r;
  logic first_r;
  logic edge_in;
  logic flag_hit;
  logic abort_hit;
  logic destuff;
  logic data_bit;
  logic oct_done;
  logic [7:0] oct;
  logic dest_full;
  logic frame_ok;

  assign edge_in = val_s2_r && !val_s3_r;
  assign flag_hit = edge_in && ({bit_s2_r, win_r[7:1]} == FLAG_OCTET); // see (R3)
  assign abort_hit = edge_in && bit_s2_r && (rones_r == FLAG_RUN);
  assign destuff = edge_in && !bit_s2_r && (rones_r == STUFF_RUN); // see (R17)
  assign data_bit = edge_in && !destuff && !flag_hit;
  assign oct_done = data_bit && (rbc_r == OCT_LAST_BIT);
  assign oct = {bit_s2_r, rb_r[7:1]};
  assign dest_full = !oct[0] && (rdc_r == 4'(MAX_DEST - 1)); // see (R15)
  // Closing flag must sit on an octet boundary after at least a control octet
  assign frame_ok = (rbc_r == OCT_LAST_BIT) && !first_r &&
    kind_ok(I_OP_TYPE, O_RX_STAT.kind); // see (R5) (R6)

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bit_s1_r <= 1'b0;
      bit_s2_r <= 1'b0;
      val_s1_r <= 1'b0;
      val_s2_r <= 1'b0;
      val_s3_r <= 1'b0;
      win_r <= 8'h00;
      rones_r <= 3'h0;
      rb_r <= 8'h00;
      rbc_r <= 3'h0;
    end else begin
      bit_s1_r <= I_RX_BIT;
      bit_s2_r <= bit_s1_r;
      val_s1_r <= I_RX_BIT_VALID;
      val_s2_r <= val_s1_r;
      val_s3_r <= val_s2_r;
      if (edge_in) begin
        win_r <= {bit_s2_r, win_r[7:1]};
        rones_r <= !bit_s2_r ? 3'h0 : (rones_r == FLAG_RUN) ? FLAG_RUN : rones_r + 3'h1;
      end
      if (flag_hit) begin
        rbc_r <= 3'h0;
      end else if (data_bit) begin
        rb_r <= oct;
        rbc_r <= rbc_r + 3'h1;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rx_st_r <= RX_HUNT;
      rdc_r <= 4'h0;
      first_r <= 1'b0;
      O_RX_DEST <= 7'h00;
      O_RX_DEST_VALID <= 1'b0;
      O_RX_DATA <= 8'h00;
      O_RX_DATA_VALID <= 1'b0;
      O_RX_END <= 1'b0;
      O_RX_STAT <= '0;
      O_RX_ERR <= 1'b0;
    end else begin
      O_RX_DEST_VALID <= 1'b0;
      O_RX_DATA_VALID <= 1'b0;
      O_RX_END <= 1'b0;
      O_RX_ERR <= 1'b0;
      if (abort_hit || I_ADDR_FOUR) begin
        rx_st_r <= RX_HUNT; // see (R8)
      end else if (flag_hit) begin
        rx_st_r <= RX_SRC; // see (R3)
        O_RX_END <= (rx_st_r == RX_BODY);
        O_RX_STAT.ok <= (rx_st_r == RX_BODY) && frame_ok;
        O_RX_ERR <= (rx_st_r == RX_DEST) || (rx_st_r == RX_BODY && !frame_ok);
      end else if (oct_done) begin
        unique case (rx_st_r)
          RX_HUNT: rx_st_r <= RX_HUNT;
          RX_SRC: begin
            O_RX_STAT <= '{src: oct[7:1], resp: oct[0], kind: KIND_NONE, ok: 1'b0}; // see (R10) (R14)
            rdc_r <= 4'h0;
            rx_st_r <= RX_DEST; // see (R1)
          end
          RX_DEST: begin
            O_RX_DEST <= oct[7:1]; // see (R11)
            O_RX_DEST_VALID <= (oct[7:1] != 7'h00); // see (R16)
            rdc_r <= rdc_r + 4'h1;
            first_r <= 1'b1;
            if (oct[0]) begin
              rx_st_r <= RX_BODY; // see (R13)
            end else if (dest_full) begin
              rx_st_r <= RX_HUNT;
              O_RX_ERR <= 1'b1;
            end
          end
          RX_BODY: begin
            O_RX_DATA <= oct;
            O_RX_DATA_VALID <= 1'b1;
            first_r <= 1'b0;
            O_RX_STAT.kind <= first_r ? kind_of(oct) : O_RX_STAT.kind;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);

  sequence s_open_done;
    (tx_st_r == TX_OPEN) && ld;
  endsequence

  sequence s_flag_out;
    (O_TX_BIT_VALID && !O_TX_BIT) ##1 (O_TX_BIT_VALID && O_TX_BIT) [*6] ##1
      (O_TX_BIT_VALID && !O_TX_BIT);
  endsequence

  property p_src_after_flag;
    s_open_done ##1 (tx_st_r == TX_SRC) |-> ##[0:12] (ld && ld_oct[0] == hdr_r.resp);
  endproperty
  a_src_after_flag: assert property (p_src_after_flag) else $error("source octet late"); // see (R1)

  property p_flag_bits;
    ld && !ld_stuff |-> ##2 s_flag_out;
  endproperty
  a_flag_bits: assert property (p_flag_bits) else $error("flag pattern wrong"); // see (R2)

  property p_rx_sync;
    flag_hit && !abort_hit && !I_ADDR_FOUR |=> (rx_st_r == RX_SRC);
  endproperty
  a_rx_sync: assert property (p_rx_sync) else $error("no sync on flag"); // see (R3)

  property p_unnum_ok;
    (tx_st_r == TX_IDLE) && I_TX_START && (I_TX_HDR.kind == KIND_UNNUM) && !I_ADDR_FOUR &&
      ndest_ok |=> (tx_st_r == TX_OPEN) && !O_TX_ERR;
  endproperty
  a_unnum_ok: assert property (p_unnum_ok) else $error("unnumbered refused"); // see (R4)

  property p_info_conn;
    (tx_st_r == TX_IDLE) && I_TX_START && (I_TX_HDR.kind == KIND_INFO) &&
      (I_OP_TYPE != OP_CONN) |=> (tx_st_r == TX_DROP) && O_TX_ERR;
  endproperty
  a_info_conn: assert property (p_info_conn) else $error("information frame sent"); // see (R5)

  property p_super_unack;
    (tx_st_r == TX_IDLE) && I_TX_START && (I_TX_HDR.kind == KIND_SUPER) &&
      (I_OP_TYPE == OP_UNACK) |=> (tx_st_r == TX_DROP) && O_TX_ERR;
  endproperty
  a_super_unack: assert property (p_super_unack) else $error("supervisory sent"); // see (R6)

  property p_four_refused;
    (tx_st_r == TX_IDLE) && I_TX_START && I_ADDR_FOUR |=> O_TX_ERR;
  endproperty
  a_four_refused: assert property (p_four_refused) else $error("four-octet accepted"); // see (R8)

  property p_dest_chain;
    ld && (tx_st_r == TX_DEST) |=> ((tx_st_r == TX_BODY) == $past(ld_oct[0]));
  endproperty
  a_dest_chain: assert property (p_dest_chain) else $error("extension bit wrong"); // see (R12)

  property p_stuff;
    stuff_now |=> O_TX_BIT_VALID && !O_TX_BIT && (ones_r == 3'h0);
  endproperty
  a_stuff: assert property (p_stuff) else $error("zero not stuffed"); // see (R17)

  property p_rx_zero;
    oct_done && (rx_st_r == RX_DEST) && (oct[7:1] == 7'h00) && !flag_hit && !abort_hit &&
      !I_ADDR_FOUR |=> !O_RX_DEST_VALID;
  endproperty
  a_rx_zero: assert property (p_rx_zero) else $error("zero address passed"); // see (R16)

  property p_rx_limit;
    oct_done && (rx_st_r == RX_DEST) && dest_full && !abort_hit && !I_ADDR_FOUR |=>
      O_RX_ERR && (rx_st_r == RX_HUNT);
  endproperty
  a_rx_limit: assert property (p_rx_limit) else $error("too many destinations"); // see (R15)

endmodule
`default_nettype wire

// file: verif/link_peer_model.sv
// Peer station model: frames octets onto the receive pins and records the transmit line
`timescale 1ns/1ps
`default_nettype none
module link_peer_model
  import link_frame_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_tx_bit,
  input wire logic i_tx_bit_valid,
  output logic o_rx_bit,
  output logic o_rx_bit_valid
);
  logic bits[$];
  logic txq[$];

  initial begin
    o_rx_bit = 1'b0;
    o_rx_bit_valid = 1'b0;
  end

  // Every valid transmit bit is kept, so stuffed zeros are counted too
  always @(posedge i_clk) begin
    if (i_tx_bit_valid) begin
      txq.push_back(i_tx_bit);
    end
  end

  // Octets go out in the order given, LSB first, between two flags
  task automatic frame(input logic [7:0] oct[$]);
    int ones;
    logic b;
    bits.delete();
    ones = 0;
    for (int i = 0; i < 8; i++) bits.push_back(FLAG_OCTET[i]);
    foreach (oct[k]) begin
      for (int i = 0; i < 8; i++) begin
        b = oct[k][i];
        bits.push_back(b);
        ones = b ? ones + 1 : 0;
        if (ones == 5) begin
          bits.push_back(1'b0);
          ones = 0;
        end
      end
    end
    for (int i = 0; i < 8; i++) bits.push_back(FLAG_OCTET[i]);
  endtask

  // Slow line: bit settles 4 cycles before the rising strobe and holds after it
  task automatic send();
    foreach (bits[i]) begin
      @(posedge i_clk);
      o_rx_bit <= bits[i];
      o_rx_bit_valid <= 1'b0;
      repeat (4) @(posedge i_clk);
      o_rx_bit_valid <= 1'b1;
      repeat (4) @(posedge i_clk);
    end
    @(posedge i_clk);
    o_rx_bit_valid <= 1'b0;
    // Released line shows the inverse so a stale value is never trusted
    o_rx_bit <= !bits[bits.size()-1];
  endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench of the link framer with a peer station model
`timescale 1ns/1ps
`default_nettype none
module testbench
  import link_frame_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  op_type_t op = OP_CONN;
  logic four = 1'b0;
  logic tx_start = 1'b0;
  tx_hdr_t tx_hdr = '0;
  logic tx_valid = 1'b0;
  tx_word_t tx_word = '0;
  logic tx_busy, tx_err, tx_ready, tx_bit, tx_bit_valid, rx_bit, rx_bit_valid;
  logic [6:0] rx_dest;
  logic [7:0] rx_data;
  logic rx_dest_valid, rx_data_valid, rx_end, rx_err;
  rx_stat_t rx_stat, stat_end;
  int bad_count = 0;
  int n_compared = 0;
  int n_end, n_err;
  logic [6:0] dq[$];
  logic [7:0] bq[$];

  always #2 clk = ~clk;

  link_frame_addressing i_dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_OP_TYPE(op),
    .I_ADDR_FOUR(four), .I_TX_START(tx_start), .I_TX_HDR(tx_hdr), .O_TX_BUSY(tx_busy),
    .O_TX_ERR(tx_err), .I_TX_VALID(tx_valid), .I_TX_WORD(tx_word), .O_TX_READY(tx_ready),
    .O_TX_BIT(tx_bit), .O_TX_BIT_VALID(tx_bit_valid), .I_RX_BIT(rx_bit),
    .I_RX_BIT_VALID(rx_bit_valid), .O_RX_DEST(rx_dest), .O_RX_DEST_VALID(rx_dest_valid),
    .O_RX_DATA(rx_data), .O_RX_DATA_VALID(rx_data_valid), .O_RX_END(rx_end),
    .O_RX_STAT(rx_stat), .O_RX_ERR(rx_err));

  link_peer_model i_peer (.i_clk(clk), .i_tx_bit(tx_bit), .i_tx_bit_valid(tx_bit_valid),
    .o_rx_bit(rx_bit), .o_rx_bit_valid(rx_bit_valid));

  always @(posedge clk) begin
    if (rx_dest_valid) dq.push_back(rx_dest);
    if (rx_data_valid) bq.push_back(rx_data);
    if (rx_err) n_err++;
    if (rx_end) begin
      n_end++;
      stat_end = rx_stat;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Called at a clock edge; returns at the edge that took the word
  task automatic push(input logic last, input logic [7:0] d);
    tx_valid <= 1'b1;
    tx_word <= {last, d};
    @(posedge clk);
    for (int n = 0; n < 500 && tx_ready !== 1'b1; n++) @(posedge clk);
    // A FIFO that never frees up is a failure, not a silent skip
    if (tx_ready !== 1'b1) bad_count++;
  endtask

  task automatic start(input logic [6:0] src, input logic resp, input frame_kind_t k,
                       input logic [4:0] nd, input logic exp_err);
    tx_valid <= 1'b0;
    tx_start <= 1'b1;
    tx_hdr <= {src, resp, k, nd};
    @(posedge clk);
    tx_start <= 1'b0;
    #1 chk("tx_err", exp_err, tx_err);
    chk("tx_busy", 1, tx_busy);
    for (int n = 0; n < 500 && tx_busy !== 1'b0; n++) @(posedge clk);
    chk("tx_idle", 0, tx_busy);
    // Closing flag still shifts out after busy drops
    repeat (16) @(posedge clk);
  endtask

  task automatic one(input frame_kind_t k, input logic [4:0] nd, input logic e);
    for (int i = 0; i < nd; i++) push(1'b0, 8'h01);
    push(1'b1, k == KIND_INFO ? 8'h00 : (k == KIND_SUPER ? 8'h01 : 8'h03));
    start(7'h01, 1'b0, k, nd, e);
  endtask

  task automatic test_tx();
    logic [7:0] o[$];
    o = '{8'hAB, 8'h24, 8'hFF, 8'h00, 8'hFF, 8'h3E, 8'h81, 8'h00, 8'h7E};
    i_peer.txq.delete();
    push(1'b0, 8'h12);
    push(1'b0, 8'h7F);
    for (int i = 3; i < 9; i++) push(i == 8, o[i]);
    tx_valid <= 1'b0;
    #1 chk("tx_ready_full", 0, tx_ready);
    @(posedge clk);
    start(7'h55, 1'b1, KIND_INFO, 5'h02, 1'b0);
    chk("tx_ready_empty", 1, tx_ready);
    i_peer.frame(o);
    chk("tx_len", i_peer.bits.size(), i_peer.txq.size());
    for (int i = 0; i < i_peer.bits.size(); i++) begin
      chk("tx_bit", i_peer.bits[i], i_peer.txq[i]);
    end
    $display("test_tx done");
  endtask

  task automatic test_kinds();
    logic legal;
    for (int o = 0; o < 4; o++) begin
      for (int j = 0; j < 3; j++) begin
        op <= op_type_t'(o);
        legal = j == 0 || (j == 1 && o == 1) || (j == 2 && (o == 1 || o == 3));
        one(frame_kind_t'(j), 5'h01, !legal);
      end
    end
    op <= OP_CONN;
    one(KIND_UNNUM, 5'h00, 1'b1);
    four <= 1'b1;
    one(KIND_UNNUM, 5'h01, 1'b1);
    four <= 1'b0;
    $display("test_kinds done");
  endtask

  task automatic rx(input logic [7:0] o[$], input logic [6:0] ed[$], input logic [7:0] eb[$],
                    input rx_stat_t es, input int ee);
    dq.delete();
    bq.delete();
    n_end = 0;
    n_err = 0;
    i_peer.frame(o);
    i_peer.send();
    repeat (20) @(posedge clk);
    chk("rx_dests", ed.size(), dq.size());
    foreach (ed[i]) chk("rx_dest", ed[i], dq[i]);
    chk("rx_body", eb.size(), bq.size());
    foreach (eb[i]) chk("rx_data", eb[i], bq[i]);
    chk("rx_end", 1, n_end);
    chk("rx_stat", es, stat_end);
    chk("rx_err", ee, n_err);
    $display("test_rx done");
  endtask

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    test_tx();
    test_kinds();
    rx('{8'h54, 8'h22, 8'h00, 8'hFF, 8'h03, 8'h7E, 8'hA5}, '{7'h11, 7'h7F},
       '{8'h03, 8'h7E, 8'hA5}, {7'h2A, 1'b0, KIND_UNNUM, 1'b1}, 0);
    op <= OP_UNACK;
    rx('{8'h55, 8'h03, 8'h01, 8'h00}, '{7'h01}, '{8'h01, 8'h00},
       {7'h2A, 1'b1, KIND_SUPER, 1'b0}, 1);
    conclude();
  end

  // Whole run needs well under 10000 cycles
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule
`default_nettype wire
